/* rtl/cbt_core.sv */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cbt_core
    import cbt_pkg::*;
#(
    parameter int RECESSIVE_RUN  = 11,
    parameter int RECOVERY_RUNS  = 128
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              bus_receive_pin,
    output logic                   bus_transmit_pin,
    input  wire cbt_field_t        frame_field,
    input  wire logic              tx_active,
    input  wire logic              tx_bit,
    input  wire logic              rx_load_ok,
    input  wire logic              rx_buffer_sel,
    input  wire logic              rx_overflow,
    input  wire logic [2:0]        tx_buffer_empty,
    input  wire logic              bus_wake,
    output logic                   retransmit_req,
    output logic                   error_frame_active,
    output logic                   cpu_irq
);

    if (RECESSIVE_RUN < 2 || RECESSIVE_RUN > 16) begin : g_bad_run
        $error("RECESSIVE_RUN must lie in 2..16");
    end
    if (RECOVERY_RUNS < 1 || RECOVERY_RUNS > 256) begin : g_bad_recov
        $error("RECOVERY_RUNS must lie in 1..256");
    end

    localparam logic [3:0] RUN_LAST   = 4'(RECESSIVE_RUN - 1);
    localparam logic [7:0] RECOV_LAST = 8'(RECOVERY_RUNS - 1);

    cbt_state_t s_q;
    cbt_state_t s_d;

    // priority encoder, lowest code wins
    function automatic logic [2:0] int_code(input logic [7:0] p);
        if (p[FL_ERR]) begin
            int_code = IC_ERR;
        end else if (p[FL_TX2]) begin
            int_code = IC_TX2;
        end else if (p[FL_TX1]) begin
            int_code = IC_TX1;
        end else if (p[FL_TX0]) begin
            int_code = IC_TX0;
        end else if (p[FL_RX1]) begin
            int_code = IC_RX1;
        end else if (p[FL_RX0]) begin
            int_code = IC_RX0;
        end else if (p[FL_WAKE]) begin
            int_code = IC_WAKE;
        end else begin
            int_code = IC_NONE;
        end
    endfunction

    function automatic logic [3:0] tq_len(input logic [2:0] f);
        tq_len = {1'b0, f} + 4'h1;
    endfunction

    function automatic logic [14:0] crc_step(input logic [14:0] c,
                                             input logic        b);
        crc_step = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? CRC_POLY : 15'h0000);
    endfunction

    logic [3:0]  ph1_tq;
    logic [3:0]  ph2_tq;
    logic [5:0]  sp_hq;
    logic [5:0]  bit_hq;
    logic [7:0]  pending;
    logic [2:0]  interrupt_code;
    logic [4:0]  extended_interrupt_code;
    logic [4:0]  stat;
    logic        passive;
    logic        cfg;
    logic        stuff_zone;

    always_comb begin
        cfg     = s_q.control[CTL_CONFIG];
        ph1_tq  = tq_len(s_q.segments[5:3]);
        if (s_q.segments[7]) begin
            ph2_tq = tq_len(s_q.phase_two[2:0]);
        end else if (ph1_tq > IPT_TQ) begin
            ph2_tq = ph1_tq;
        end else begin
            ph2_tq = IPT_TQ;
        end
        sp_hq   = {5'(5'h01 + 5'(tq_len(s_q.segments[2:0]))
                      + 5'(ph1_tq)), 1'b0};
        bit_hq  = 6'(sp_hq + {1'b0, ph2_tq, 1'b0});
        pending = s_q.flags & s_q.enables;
        interrupt_code   = int_code(pending);
        if (s_q.control[CTL_FIFO]
                && (interrupt_code == IC_RX0 || interrupt_code == IC_RX1)) begin
            extended_interrupt_code = EIC_FIFO_RX;
        end else begin
            extended_interrupt_code = {2'b00, interrupt_code};
        end
        passive = (s_q.tec >= PASSIVE_LIMIT)
                || ({1'b0, s_q.rec} >= PASSIVE_LIMIT);
        stat    = {s_q.busoff, s_q.tec >= PASSIVE_LIMIT,
                   {1'b0, s_q.rec} >= PASSIVE_LIMIT,
                   s_q.tec >= WARN_LIMIT,
                   {1'b0, s_q.rec} >= WARN_LIMIT};
        stuff_zone = frame_field == FLD_SOF || frame_field == FLD_ARB
                || frame_field == FLD_CTRL || frame_field == FLD_DATA
                || frame_field == FLD_CRC;
    end

    function automatic logic [31:0] rd_word(input logic [APB_AW-1:0] a,
                                            input cbt_state_t        s,
                                            input logic [4:0]        st,
                                            input logic [2:0]        ic,
                                            input logic [4:0]        ec);
        case (a)
            OFS_PRESCALE:  rd_word = {24'h000000, s.prescale};
            OFS_SEGMENTS:  rd_word = {24'h000000, s.segments};
            OFS_PHASE_TWO: rd_word = {24'h000000, s.phase_two};
            OFS_CONTROL:   rd_word = {30'h00000000, s.control};
            OFS_ERR_COUNT: rd_word = {7'h00, s.tec, 8'h00, s.rec};
            OFS_COMM_STAT: rd_word = {16'h0000, 3'h0, s.cause, 1'b0,
                                      s.ovfl, st, st[1] | st[0]};
            OFS_FLAGS:     rd_word = {24'h000000, s.flags};
            OFS_ENABLES:   rd_word = {24'h000000, s.enables};
            OFS_CTRL_STAT: rd_word = {16'h0000, 3'h0, ec, 4'h0, ic, 1'b0};
            default:       rd_word = 32'h00000000;
        endcase
    endfunction

    function automatic logic mapped(input logic [APB_AW-1:0] a);
        case (a)
            OFS_PRESCALE, OFS_SEGMENTS, OFS_PHASE_TWO, OFS_CONTROL,
            OFS_ERR_COUNT, OFS_COMM_STAT, OFS_FLAGS, OFS_ENABLES,
            OFS_CTRL_STAT: mapped = 1'b1;
            default:       mapped = 1'b0;
        endcase
    endfunction

    always_comb begin
        logic        wr;
        logic        b;
        logic [4:0]  e;
        logic        good;
        logic [7:0]  set;
        wr   = psel && penable && s_q.pready && pwrite;
        b    = s_q.bit_rx;
        e    = 5'h00;
        good = 1'b0;
        set  = 8'h00;
        s_d  = s_q;
        s_d.bit_valid = 1'b0;
        s_d.retx      = 1'b0;

        // apb: answer registered at setup, zero wait states
        s_d.pready = psel && !penable && !s_q.pready;
        if (psel && !penable) begin
            s_d.prdata  = rd_word(paddr, s_q, stat, interrupt_code, extended_interrupt_code);
            s_d.pslverr = !mapped(paddr);
        end
        if (wr) begin
            case (paddr)
                OFS_PRESCALE: begin
                    if (cfg) begin
                        s_d.prescale = pwdata[7:0];
                    end
                end
                OFS_SEGMENTS: begin
                    if (cfg) begin
                        s_d.segments = pwdata[7:0];
                    end
                end
                OFS_PHASE_TWO: begin
                    if (cfg) begin
                        s_d.phase_two = pwdata[7:0];
                    end
                end
                OFS_CONTROL: s_d.control = pwdata[1:0];
                OFS_COMM_STAT: begin
                    s_d.ovfl  = s_q.ovfl & pwdata[6];
                    s_d.cause = s_q.cause & pwdata[12:8];
                end
                OFS_FLAGS:   s_d.flags   = s_q.flags & pwdata[7:0];
                OFS_ENABLES: s_d.enables = pwdata[7:0];
                default: ;
            endcase
        end

        // bit timer in half quanta; prescaler field is half quantum - 1
        s_d.rx_prev = bus_receive_pin;
        if (cfg) begin
            s_d.hq_cnt = 6'h00;
            s_d.hq_pos = 6'h00;
        end else if ((frame_field == FLD_IDLE) && s_q.rx_prev
                && !bus_receive_pin) begin
            s_d.hq_cnt = 6'h00;
            s_d.hq_pos = 6'h00;
        end else if (s_q.hq_cnt == s_q.prescale[5:0]) begin
            s_d.hq_cnt = 6'h00;
            s_d.hq_pos = (s_q.hq_pos == 6'(bit_hq - 6'h01)) ? 6'h00
                       : 6'(s_q.hq_pos + 6'h01);
            if (s_q.hq_pos == 6'(sp_hq - 6'h02)) begin
                s_d.early[0] = bus_receive_pin;
            end
            if (s_q.hq_pos == 6'(sp_hq - 6'h01)) begin
                s_d.early[1] = bus_receive_pin;
            end
            if (s_q.hq_pos == sp_hq) begin
                s_d.bit_valid = 1'b1;
                s_d.bit_rx = s_q.segments[6]
                    ? ((s_q.early[0] & s_q.early[1])
                       | (s_q.early[0] & bus_receive_pin)
                       | (s_q.early[1] & bus_receive_pin))
                    : bus_receive_pin;
            end
        end else begin
            s_d.hq_cnt = 6'(s_q.hq_cnt + 6'h01);
        end

        // bus-off recovery counts recessive runs; otherwise error flag countdown, then frame checks
        if (s_q.bit_valid && s_q.busoff) begin
            if (b) begin
                if (s_q.ones_run == RUN_LAST) begin
                    s_d.ones_run = 4'h0;
                    if (s_q.recov_cnt == RECOV_LAST) begin
                        s_d.busoff    = 1'b0;
                        s_d.recov_cnt = 8'h00;
                        s_d.tec       = 9'h000;
                        s_d.rec       = 8'h00;
                    end else begin
                        s_d.recov_cnt = 8'(s_q.recov_cnt + 8'h01);
                    end
                end else begin
                    s_d.ones_run = 4'(s_q.ones_run + 4'h1);
                end
            end else begin
                s_d.ones_run = 4'h0;
            end
        end else if (s_q.bit_valid && !cfg && s_q.err_cnt != 3'h0) begin
            s_d.err_cnt = 3'(s_q.err_cnt - 3'h1);
        end else if (s_q.bit_valid && !cfg) begin
            if (frame_field == FLD_SOF) begin
                s_d.run_len   = 3'h1;
                s_d.run_bit   = b;
                s_d.crc       = crc_step(15'h0000, b);
                s_d.frame_err = 1'b0;
                s_d.eof_cnt   = 3'h0;
            end else if (stuff_zone) begin
                if (s_q.run_len == STUFF_RUN) begin
                    if (b == s_q.run_bit) begin
                        e[CS_STUFF] = 1'b1;
                    end else begin
                        s_d.run_len = 3'h1;
                        s_d.run_bit = b;
                    end
                end else begin
                    s_d.run_len = (b == s_q.run_bit)
                                ? 3'(s_q.run_len + 3'h1) : 3'h1;
                    s_d.run_bit = b;
                    if (frame_field == FLD_CRC) begin
                        s_d.rx_crc = {s_q.rx_crc[13:0], b};
                    end else begin
                        s_d.crc = crc_step(s_q.crc, b);
                    end
                end
            end
            if (frame_field == FLD_CRC_DELIM && s_q.rx_crc != s_q.crc) begin
                e[CS_CRC] = 1'b1;
            end
            if (frame_field == FLD_ACK_SLOT && tx_active && b) begin
                e[CS_ACK] = 1'b1;
            end
            if (!b && (frame_field == FLD_CRC_DELIM
                    || frame_field == FLD_ACK_DELIM
                    || frame_field == FLD_EOF
                    || frame_field == FLD_IFS)) begin
                e[CS_FORM] = 1'b1;
            end
            if (tx_active && b != tx_bit
                    && !(tx_bit && !b && (frame_field == FLD_ARB
                         || frame_field == FLD_ACK_SLOT))) begin
                e[CS_BIT] = 1'b1;
            end
            if (frame_field == FLD_EOF) begin
                s_d.eof_cnt = 3'(s_q.eof_cnt + 3'h1);
                good = (s_q.eof_cnt == EOF_LAST) && !s_q.frame_err && b;
            end
            if (e != 5'h00) begin
                s_d.frame_err = 1'b1;
                s_d.cause     = s_d.cause | e;
                s_d.err_cnt   = ERR_FLAG_BITS;
                set[FL_MSGERR] = 1'b1;
                if (tx_active) begin
                    s_d.retx = 1'b1;
                    s_d.tec  = (s_q.tec >= BUSOFF_LIMIT) ? s_q.tec
                             : 9'(s_q.tec + TEC_STEP);
                end else if (s_q.rec != REC_MAX) begin
                    s_d.rec = 8'(s_q.rec + 8'h01);
                end
            end else if (good) begin
                if (tx_active) begin
                    if (s_q.tec != 9'h000) begin
                        s_d.tec = 9'(s_q.tec - 9'h001);
                    end
                end else begin
                    if (s_q.rec != 8'h00) begin
                        s_d.rec = 8'(s_q.rec - 8'h01);
                    end
                    if (rx_load_ok) begin
                        if (rx_buffer_sel && !s_q.control[CTL_FIFO]) begin
                            set[FL_RX1] = 1'b1;
                        end else begin
                            set[FL_RX0] = 1'b1;
                        end
                    end
                end
            end
        end
        if (s_d.tec >= BUSOFF_LIMIT) begin
            s_d.busoff = 1'b1;
            s_d.err_cnt = 3'h0;
            s_d.retx    = 1'b0;
        end

        // event sources; a set beats a same-cycle software clear
        s_d.stat_prev = stat;
        if (rx_overflow) begin
            s_d.ovfl = 1'b1;
        end
        set[FL_ERR]  = (stat != s_q.stat_prev) || rx_overflow;
        set[FL_TX0]  = tx_buffer_empty[0];
        set[FL_TX1]  = tx_buffer_empty[1];
        set[FL_TX2]  = tx_buffer_empty[2];
        set[FL_WAKE] = bus_wake;
        s_d.flags = s_d.flags | set;
        s_d.irq   = |(s_d.flags & s_d.enables);

        if (s_d.busoff) begin
            s_d.can_tx = 1'b1;
        end else if (s_d.err_cnt != 3'h0) begin
            s_d.can_tx = passive;
        end else begin
            s_d.can_tx = tx_active ? tx_bit : 1'b1;
        end
        s_d.err_frame = s_d.err_cnt != 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q           <= '0;
            s_q.prescale  <= TIMING_RESET;
            s_q.segments  <= TIMING_RESET;
            s_q.phase_two <= TIMING_RESET;
            s_q.control   <= CONTROL_RESET;
            s_q.rx_prev   <= 1'b1;
            s_q.run_bit   <= 1'b1;
            s_q.can_tx    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata             = s_q.prdata;
    assign pready             = s_q.pready;
    assign pslverr            = s_q.pslverr;
    assign bus_transmit_pin   = s_q.can_tx;
    assign retransmit_req     = s_q.retx;
    assign error_frame_active = s_q.err_frame;
    assign cpu_irq            = s_q.irq;

endmodule
`default_nettype wire

/* rtl/cbt_pkg.sv */
package cbt_pkg;

    localparam int          APB_AW          = 8;
    localparam logic [7:0]  OFS_PRESCALE    = 8'h00;
    localparam logic [7:0]  OFS_SEGMENTS    = 8'h04;
    localparam logic [7:0]  OFS_PHASE_TWO   = 8'h08;
    localparam logic [7:0]  OFS_CONTROL     = 8'h0c;
    localparam logic [7:0]  OFS_ERR_COUNT   = 8'h10;
    localparam logic [7:0]  OFS_COMM_STAT   = 8'h14;
    localparam logic [7:0]  OFS_FLAGS       = 8'h18;
    localparam logic [7:0]  OFS_ENABLES     = 8'h1c;
    localparam logic [7:0]  OFS_CTRL_STAT   = 8'h20;

    localparam logic [7:0]  TIMING_RESET    = 8'h00;
    localparam logic [1:0]  CONTROL_RESET   = 2'h1;
    localparam int          CTL_CONFIG      = 0;
    localparam int          CTL_FIFO        = 1;

    // flag and enable bit positions
    localparam int          FL_RX0          = 0;
    localparam int          FL_RX1          = 1;
    localparam int          FL_TX0          = 2;
    localparam int          FL_TX1          = 3;
    localparam int          FL_TX2          = 4;
    localparam int          FL_ERR          = 5;
    localparam int          FL_WAKE         = 6;
    localparam int          FL_MSGERR       = 7;

    // error cause bit positions
    localparam int          CS_CRC          = 0;
    localparam int          CS_ACK          = 1;
    localparam int          CS_FORM         = 2;
    localparam int          CS_BIT          = 3;
    localparam int          CS_STUFF        = 4;

    localparam logic [2:0]  IC_NONE         = 3'h0;
    localparam logic [2:0]  IC_ERR          = 3'h1;
    localparam logic [2:0]  IC_TX2          = 3'h2;
    localparam logic [2:0]  IC_TX1          = 3'h3;
    localparam logic [2:0]  IC_TX0          = 3'h4;
    localparam logic [2:0]  IC_RX1          = 3'h5;
    localparam logic [2:0]  IC_RX0          = 3'h6;
    localparam logic [2:0]  IC_WAKE         = 3'h7;
    localparam logic [4:0]  EIC_FIFO_RX     = 5'h10;

    localparam logic [8:0]  WARN_LIMIT      = 9'h060;
    localparam logic [8:0]  PASSIVE_LIMIT   = 9'h080;
    localparam logic [8:0]  BUSOFF_LIMIT    = 9'h100;
    localparam logic [8:0]  TEC_STEP        = 9'h008;
    localparam logic [7:0]  REC_MAX         = 8'hff;
    localparam logic [3:0]  IPT_TQ          = 4'h2;
    localparam logic [2:0]  ERR_FLAG_BITS   = 3'h6;
    localparam logic [2:0]  STUFF_RUN       = 3'h5;
    localparam logic [2:0]  EOF_LAST        = 3'h6;
    localparam logic [14:0] CRC_POLY        = 15'h4599;

    typedef enum logic [3:0] {
        FLD_IDLE      = 4'b0000,
        FLD_SOF       = 4'b0001,
        FLD_ARB       = 4'b0010,
        FLD_CTRL      = 4'b0011,
        FLD_DATA      = 4'b0100,
        FLD_CRC       = 4'b0101,
        FLD_CRC_DELIM = 4'b0110,
        FLD_ACK_SLOT  = 4'b0111,
        FLD_ACK_DELIM = 4'b1000,
        FLD_EOF       = 4'b1001,
        FLD_IFS       = 4'b1010
    } cbt_field_t;

    typedef struct packed {
        logic [7:0]  prescale;
        logic [7:0]  segments;
        logic [7:0]  phase_two;
        logic [1:0]  control;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic        ovfl;
        logic [4:0]  cause;
        logic [8:0]  tec;
        logic [7:0]  rec;
        logic        busoff;
        logic [3:0]  ones_run;
        logic [7:0]  recov_cnt;
        logic [5:0]  hq_cnt;
        logic [5:0]  hq_pos;
        logic [1:0]  early;
        logic        bit_valid;
        logic        bit_rx;
        logic        rx_prev;
        logic [2:0]  run_len;
        logic        run_bit;
        logic [14:0] crc;
        logic [14:0] rx_crc;
        logic [2:0]  eof_cnt;
        logic        frame_err;
        logic [2:0]  err_cnt;
        logic [4:0]  stat_prev;
        logic        can_tx;
        logic        retx;
        logic        err_frame;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cbt_state_t;

endpackage

/* testbench/cbt_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module cbt_sva
    import cbt_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              retransmit_req,
    input wire logic              error_frame_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_map;
        psel && !penable && paddr < 8'h24 && !paddr[1:0] |=> !pslverr;
    endproperty
    property p_code;
        pready && !pwrite && paddr == OFS_CTRL_STAT |-> prdata[31:13] == 0;
    endproperty
    property p_cnt;
        pready && !pwrite && paddr == OFS_ERR_COUNT |-> prdata[15:8] == 0;
    endproperty
    property p_pulse; retransmit_req |=> !retransmit_req; endproperty
    property p_ef; retransmit_req |-> error_frame_active; endproperty
    property p_hold;
        $rose(error_frame_active) |-> error_frame_active [*8];
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    a_one: assert property (p_one) else $error("long ready");
    a_map: assert property (p_map) else $error("bad slverr");
    a_code: assert property (p_code) else $error("code bits");
    a_cnt: assert property (p_cnt) else $error("count bits");
    a_pulse: assert property (p_pulse) else $error("long retx");
    a_ef: assert property (p_ef) else $error("retx no flag");
    a_hold: assert property (p_hold) else $error("short flag");
    c_retx: cover property (retransmit_req);
    c_err: cover property (pslverr);
    c_end: cover property ($fell(error_frame_active));
endmodule
bind cbt_core cbt_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .retransmit_req, .error_frame_active);
`default_nettype wire

/* testbench/cbt_node.sv */
`timescale 1ns/100ps
`default_nettype none
module cbt_node
    import cbt_pkg::*;
(
    input wire logic       dut_tx,
    input wire cbt_field_t field,
    input wire logic       ack_on,
    input wire logic       pull,
    output logic           bus
);
    // wired-and bus, peer acks dominant in the slot, pull opens a frame
    assign bus = dut_tx & ~pull
               & ~(ack_on && field == FLD_ACK_SLOT);
endmodule
`default_nettype wire

/* testbench/can_bit_timing_error_irq_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_error_irq_bench;
    import cbt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, bus_wake, se;
    logic        ack_on, tx_active, tx_bit, bus, tx_pin, irq, pready, pslverr;
    logic        pull, rx_ok;
    logic [7:0]  paddr, fl, en, v;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  tx_empty, c;
    cbt_field_t  field;
    int          errors = 0, check_count = 0, tec = 0;
    int          ord[7] = '{FL_ERR, FL_TX2, FL_TX1, FL_TX0, FL_RX1, FL_RX0,
                            FL_WAKE};
    cbt_core #(.RECESSIVE_RUN(11), .RECOVERY_RUNS(2)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .bus_receive_pin(bus), .bus_transmit_pin(tx_pin),
        .frame_field(field), .tx_active, .tx_bit, .rx_load_ok(rx_ok),
        .rx_buffer_sel(1'b0), .rx_overflow(1'b0), .tx_buffer_empty(tx_empty),
        .bus_wake, .retransmit_req(), .error_frame_active(), .cpu_irq(irq));
    cbt_node peer (.dut_tx(tx_pin), .field, .ack_on, .pull, .bus);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rc(string n, logic [7:0] a, logic [31:0] m,
                      logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e & m, rd & m);
    endtask
    function automatic logic [2:0] code(logic [7:0] p);
        for (int j = 0; j < 7; j++)
            if (p[ord[j]]) return 3'(j + 1);
        return 3'h0;
    endfunction
    function automatic logic [31:0] stat(int t, logic [4:0] k);
        return {19'h0, k, 2'b0, t >= 256, t >= 128, 1'b0,
                t >= 96, 1'b0, t >= 96};
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, bus_wake, ack_on, tx_active} = '0;
        {tx_bit, paddr, pwdata, tx_empty, pull, rx_ok} = '0;
        field = FLD_IDLE;
        v = 8'($urandom(32'h090b)) | 8'h08;
        en = 8'($urandom);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rc("ctl", OFS_CONTROL, 32'h3, 32'h1);
        rc("seg", OFS_SEGMENTS, 32'hff, 32'h0);
        apb(1'b1, OFS_PRESCALE, 32'hc0);
        rc("jump", OFS_PRESCALE, 32'hff, 32'hc0);
        apb(1'b1, OFS_PHASE_TWO, {29'h0, v[6:4]});
        rc("ph2", OFS_PHASE_TWO, 32'h7, {29'h0, v[6:4]});
        apb(1'b1, OFS_CONTROL, 32'h0);
        apb(1'b1, OFS_PHASE_TWO, {29'h0, ~v[6:4]});
        rc("lock", OFS_PHASE_TWO, 32'h7, {29'h0, v[6:4]});
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, se});
        $display("timing test done");
        apb(1'b1, OFS_ENABLES, {24'h0, en});
        {tx_empty, bus_wake} <= v[3:0];
        @(posedge pclk);
        {tx_empty, bus_wake} <= 4'h0;
        fl = {1'b0, v[0], 1'b0, v[3:1], 2'b00};
        repeat (5) begin
            c = code(fl & en);
            rc("interrupt_code", OFS_CTRL_STAT, 32'he,
               {28'h0, c, 1'b0});
            chk("irq", {31'h0, |(fl & en)}, {31'h0, irq});
            if (c != 3'h0)
                fl[ord[c - 1]] = 1'b0;
            apb(1'b1, OFS_FLAGS, {24'h0, fl});
        end
        $display("interrupt test done");
        {tx_active, tx_bit, ack_on} <= 3'b111;
        for (int i = 0; i < 33; i++) begin
            // hard sync; 10-clock bits, slot covers the second sample only
            pull <= 1'b1;
            @(posedge pclk);
            pull <= 1'b0;
            repeat (12) @(posedge pclk);
            field <= FLD_ACK_SLOT;
            repeat (10) @(posedge pclk);
            {field, ack_on} <= {FLD_IDLE, 1'b0};
            repeat (60) @(posedge pclk);
            tec += (i > 0) ? 8 : 0;
            rc("tec", OFS_ERR_COUNT, 32'h1ff00ff,
               tec << 16);
            rc("stat", OFS_COMM_STAT, 32'h1f3f,
               stat(tec, (i > 0) ? 5'h2 : 5'h0));
        end
        repeat (200) @(posedge pclk);
        rc("recov", OFS_ERR_COUNT, 32'h1ff00ff, 32'h0);
        rc("state", OFS_COMM_STAT, 32'h3f, 32'h0);
        $display("error state test done");
        // good received frame in fifo mode: sof, then seven eof bits
        apb(1'b1, OFS_CONTROL, 32'h2);
        apb(1'b1, OFS_ENABLES, 32'h1 << FL_RX0);
        {tx_active, rx_ok, pull} <= 3'b011;
        @(posedge pclk);
        {pull, field} <= {1'b0, FLD_SOF};
        repeat (10) @(posedge pclk);
        field <= FLD_EOF;
        repeat (70) @(posedge pclk);
        field <= FLD_IDLE;
        rc("extended_interrupt_code", OFS_CTRL_STAT, 32'h1f0e,
           {19'h0, EIC_FIFO_RX, 4'h0, IC_RX0, 1'b0});
        chk("rxirq", 32'h1, {31'h0, irq});
        $display("receive test done");
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        end_sim;
    end
endmodule
`default_nettype wire
